// file: core/gpcb_map.vh
/*
 * Register map, field layout and codes of the pin configuration bank.
 * Assumes inclusion by bare name from the bank's design files.
 */
`ifndef GPCB_MAP_VH
`define GPCB_MAP_VH

// ****************************************
// Register byte offsets
// ****************************************
`define GPCB_OFS_LOCK_KEY 12'h000
`define GPCB_OFS_IRQ_STATUS 12'h008
`define GPCB_OFS_IRQ_CLEAR 12'h00c
`define GPCB_OFS_IRQ_ENABLE 12'h010
`define GPCB_OFS_PIN_DATA_IN 12'h014
`define GPCB_OFS_PIN_DATA_OUT 12'h018
`define GPCB_OFS_TRI_ENABLE 12'h01c
`define GPCB_OFS_CFG_LOW 12'h040
`define GPCB_OFS_CFG_HIGH 12'h044
`define GPCB_OFS_MSB 11

// ****************************************
// Sizes, keys and reset values
// ****************************************
`define GPCB_PINS 16
`define GPCB_SLICE_W 4
`define GPCB_KEY_OPEN 32'h00000073
`define GPCB_RST_WORD 32'h00000000
`define GPCB_RST_PINS 16'h0000
`define GPCB_RST_BIT 1'b0

// ****************************************
// Slice field positions
// ****************************************
`define GPCB_FLD_EDGE 3
`define GPCB_FLD_MODE_HI 2
`define GPCB_FLD_MODE_LO 1
`define GPCB_FLD_READBACK 0

// ****************************************
// Field codes
// ****************************************
`define GPCB_RISING_EDGE_SEL 1'b0
`define GPCB_FALLING_EDGE_SEL 1'b1
`define GPCB_MODE_DISABLED 2'h0
`define GPCB_MODE_DRIVEN_BOTH_WAYS 2'h1
`define GPCB_MODE_DRAIN_OPEN 2'h2
`define GPCB_MODE_THREE_STATE 2'h3
`define GPCB_READ_PIN 1'b0
`define GPCB_READ_FORCED_LOW 1'b1

// ****************************************
// Bus codes
// ****************************************
`define GPCB_HTRANS_NONSEQ_BIT 1
`define GPCB_HRESP_OKAY 1'b0

`endif

// file: core/gpcb_pin_slice.v
/*
 * One pin: input synchroniser, edge event and output driver.
 * Assumes pinIn is asynchronous to clock and the pad resolves pinOe.
 */
`timescale 1ns/10ps
`default_nettype none
`include "gpcb_map.vh"

module gpcb_pin_slice (
    input wire clock,
    input wire resetn,
    input wire pinIn,
    input wire [3:0] cfgSlice,
    input wire dataOut,
    input wire triEnable,
    output reg pinOut,
    output reg pinOe,
    output reg level,
    output reg edgeEvt
);

// ****************************************
// Three stage synchroniser
// ****************************************
reg sync1_r;
reg sync2_r;
reg sync3_r;
wire agree;
wire [1:0] mode;

assign agree = (sync2_r == sync3_r);
assign mode = cfgSlice[`GPCB_FLD_MODE_HI:`GPCB_FLD_MODE_LO];

always @(posedge clock or negedge resetn)
begin
    if (!resetn)
    begin
        sync1_r <= `GPCB_RST_BIT;
        sync2_r <= `GPCB_RST_BIT;
        sync3_r <= `GPCB_RST_BIT;
        level <= `GPCB_RST_BIT;
        edgeEvt <= `GPCB_RST_BIT;
    end
    else
    begin
        sync1_r <= pinIn;
        sync2_r <= sync1_r;
        sync3_r <= sync2_r;
        edgeEvt <= `GPCB_RST_BIT;
        if (agree)
        begin
            level <= sync3_r;
            // Edge direction select
            if (sync3_r != level)
            begin
                if (cfgSlice[`GPCB_FLD_EDGE] == `GPCB_RISING_EDGE_SEL)
                    edgeEvt <= sync3_r;
                else
                    edgeEvt <= ~sync3_r;
            end
        end
    end
end

// ****************************************
// Output driver
// ****************************************
always @(posedge clock or negedge resetn)
begin
    if (!resetn)
    begin
        pinOut <= `GPCB_RST_BIT;
        pinOe <= `GPCB_RST_BIT;
    end
    else
    begin
        case (mode)
            `GPCB_MODE_DRIVEN_BOTH_WAYS:
            begin
                pinOut <= dataOut;
                pinOe <= 1'b1;
            end
            `GPCB_MODE_DRAIN_OPEN:
            begin
                pinOut <= 1'b0;
                pinOe <= ~dataOut;
            end
            `GPCB_MODE_THREE_STATE:
            begin
                pinOut <= dataOut;
                pinOe <= triEnable;
            end
            default:
            begin
                pinOut <= 1'b0;
                pinOe <= 1'b0;
            end
        endcase
    end
end

endmodule
`default_nettype wire

// file: core/gpcb_top.v
/*
 * Pin configuration bank for pins 0 to 15 with AHB-Lite register slave.
 * Assumes a single AHB-Lite master doing word transfers, pads outside.
 */
// Overview of operation
// - Configuration writes land only while the key lock is open.
// - Edge select 0 picks rising transitions, 1 picks falling ones.
// - Mode 0 disabled, 1 push-pull, 2 open drain, 3 three-state.
// - Readback 0 returns pin level, 1 forces that pin's read to zero.
// - Pin k of eight: edge bit 4k+3, mode 4k+2:4k+1, readback 4k.
// - Low group register holds pins 7..0, pin 7 on top nibble.
// - High group register holds pins 15..8, four bytes above low.
`timescale 1ns/10ps
`default_nettype none
`include "gpcb_map.vh"

module gpcb_top (
    input wire clock,
    input wire resetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg hreadyout,
    output reg hresp,
    output reg [31:0] hrdata,
    input wire [15:0] pinIn,
    output wire [15:0] pinOut,
    output wire [15:0] pinOe,
    output reg irq
);

// ****************************************
// Address decode helper
// ****************************************
function addrHit;
    input [`GPCB_OFS_MSB:0] addr;
    input [`GPCB_OFS_MSB:0] ofs;
    begin
        addrHit = (addr == ofs);
    end
endfunction

// ****************************************
// Registers
// ****************************************
reg [31:0] pinCfgLowGroup_r;
reg [31:0] pinCfgHighGroup_r;
reg lockOpen_r;
reg [15:0] irqStatus_r;
reg [15:0] irqEnable_r;
reg [15:0] dataOut_r;
reg [15:0] triEnable_r;

reg wrPend_r;
reg [`GPCB_OFS_MSB:0] wrAddr_r;
reg rdPend_r;
reg [`GPCB_OFS_MSB:0] rdAddr_r;

wire [63:0] cfgAll;
wire [15:0] pinLevel;
wire [15:0] pinEvt;
wire [15:0] readForce;
wire [15:0] dataIn;
wire accept;
wire [15:0] irqClear;
wire [15:0] irqStatus_nxt;
reg [31:0] rdData_nxt;

assign accept = hsel & htrans[`GPCB_HTRANS_NONSEQ_BIT] & hready;
assign cfgAll = {pinCfgHighGroup_r, pinCfgLowGroup_r};

// ****************************************
// Per pin logic
// ****************************************
genvar i;
generate
    for (i = 0; i < `GPCB_PINS; i = i + 1)
    begin : pinGen
        gpcb_pin_slice slice (
            .clock(clock),
            .resetn(resetn),
            .pinIn(pinIn[i]),
            .cfgSlice(cfgAll[`GPCB_SLICE_W*i+`GPCB_FLD_EDGE:`GPCB_SLICE_W*i]),
            .dataOut(dataOut_r[i]),
            .triEnable(triEnable_r[i]),
            .pinOut(pinOut[i]),
            .pinOe(pinOe[i]),
            .level(pinLevel[i]),
            .edgeEvt(pinEvt[i])
        );
        assign readForce[i] = cfgAll[`GPCB_SLICE_W*i+`GPCB_FLD_READBACK];
        // Forced-low readback masks the pin level
        assign dataIn[i] = (readForce[i] == `GPCB_READ_FORCED_LOW) ?
            1'b0 : pinLevel[i];
    end
endgenerate

// ****************************************
// Interrupt status
// ****************************************
assign irqClear = (wrPend_r && addrHit(wrAddr_r, `GPCB_OFS_IRQ_CLEAR)) ?
    hwdata[15:0] : `GPCB_RST_PINS;
// Set wins over a clear in the same cycle
assign irqStatus_nxt = (irqStatus_r & ~irqClear) | pinEvt;

always @(posedge clock or negedge resetn)
begin
    if (!resetn)
    begin
        irqStatus_r <= `GPCB_RST_PINS;
    end
    else
    begin
        irqStatus_r <= irqStatus_nxt;
    end
end

// ****************************************
// Interrupt output
// ****************************************
always @(posedge clock or negedge resetn)
begin
    if (!resetn)
    begin
        irq <= `GPCB_RST_BIT;
    end
    else
    begin
        irq <= |(irqStatus_nxt & irqEnable_r);
    end
end

// ****************************************
// Bus phase tracking
// ****************************************
always @(posedge clock or negedge resetn)
begin
    if (!resetn)
    begin
        wrPend_r <= `GPCB_RST_BIT;
        wrAddr_r <= {(`GPCB_OFS_MSB+1){1'b0}};
        rdPend_r <= `GPCB_RST_BIT;
        rdAddr_r <= {(`GPCB_OFS_MSB+1){1'b0}};
        hreadyout <= 1'b1;
        hresp <= `GPCB_HRESP_OKAY;
    end
    else
    begin
        hresp <= `GPCB_HRESP_OKAY;
        wrPend_r <= accept & hwrite;
        if (accept)
        begin
            wrAddr_r <= haddr[`GPCB_OFS_MSB:0];
            rdAddr_r <= haddr[`GPCB_OFS_MSB:0];
        end
        // Reads take one wait state so a write just before is seen
        if (accept && !hwrite)
        begin
            rdPend_r <= 1'b1;
            hreadyout <= 1'b0;
        end
        else
        begin
            rdPend_r <= 1'b0;
            hreadyout <= 1'b1;
        end
    end
end

// ****************************************
// Lock key
// ****************************************
always @(posedge clock or negedge resetn)
begin
    if (!resetn)
    begin
        lockOpen_r <= `GPCB_RST_BIT;
    end
    else if (wrPend_r && addrHit(wrAddr_r, `GPCB_OFS_LOCK_KEY))
    begin
        // Any value but the key closes the lock again
        lockOpen_r <= (hwdata == `GPCB_KEY_OPEN);
    end
end

// ****************************************
// Pin configuration groups
// ****************************************
always @(posedge clock or negedge resetn)
begin
    if (!resetn)
    begin
        pinCfgLowGroup_r <= `GPCB_RST_WORD;
        pinCfgHighGroup_r <= `GPCB_RST_WORD;
    end
    else if (wrPend_r && lockOpen_r)
    begin
        // Locked writes fall through here and still answer OKAY
        if (addrHit(wrAddr_r, `GPCB_OFS_CFG_LOW))
        begin
            pinCfgLowGroup_r <= hwdata;
        end
        else if (addrHit(wrAddr_r, `GPCB_OFS_CFG_HIGH))
        begin
            pinCfgHighGroup_r <= hwdata;
        end
    end
end

// ****************************************
// Interrupt enable
// ****************************************
always @(posedge clock or negedge resetn)
begin
    if (!resetn)
    begin
        irqEnable_r <= `GPCB_RST_PINS;
    end
    else if (wrPend_r && addrHit(wrAddr_r, `GPCB_OFS_IRQ_ENABLE))
    begin
        irqEnable_r <= hwdata[15:0];
    end
end

// ****************************************
// Pin output data and three-state enable
// ****************************************
always @(posedge clock or negedge resetn)
begin
    if (!resetn)
    begin
        dataOut_r <= `GPCB_RST_PINS;
        triEnable_r <= `GPCB_RST_PINS;
    end
    else if (wrPend_r)
    begin
        if (addrHit(wrAddr_r, `GPCB_OFS_PIN_DATA_OUT))
        begin
            dataOut_r <= hwdata[15:0];
        end
        else if (addrHit(wrAddr_r, `GPCB_OFS_TRI_ENABLE))
        begin
            triEnable_r <= hwdata[15:0];
        end
    end
end

// ****************************************
// Register reads
// ****************************************
always @*
begin
    rdData_nxt = `GPCB_RST_WORD;
    if (addrHit(rdAddr_r, `GPCB_OFS_LOCK_KEY))
    begin
        rdData_nxt = {31'h00000000, lockOpen_r};
    end
    else if (addrHit(rdAddr_r, `GPCB_OFS_IRQ_STATUS))
    begin
        rdData_nxt = {16'h0000, irqStatus_r};
    end
    else if (addrHit(rdAddr_r, `GPCB_OFS_IRQ_ENABLE))
    begin
        rdData_nxt = {16'h0000, irqEnable_r};
    end
    else if (addrHit(rdAddr_r, `GPCB_OFS_PIN_DATA_IN))
    begin
        rdData_nxt = {16'h0000, dataIn};
    end
    else if (addrHit(rdAddr_r, `GPCB_OFS_PIN_DATA_OUT))
    begin
        rdData_nxt = {16'h0000, dataOut_r};
    end
    else if (addrHit(rdAddr_r, `GPCB_OFS_TRI_ENABLE))
    begin
        rdData_nxt = {16'h0000, triEnable_r};
    end
    else if (addrHit(rdAddr_r, `GPCB_OFS_CFG_LOW))
    begin
        rdData_nxt = pinCfgLowGroup_r;
    end
    else if (addrHit(rdAddr_r, `GPCB_OFS_CFG_HIGH))
    begin
        rdData_nxt = pinCfgHighGroup_r;
    end
end

always @(posedge clock or negedge resetn)
begin
    if (!resetn)
    begin
        hrdata <= `GPCB_RST_WORD;
    end
    else if (rdPend_r)
    begin
        hrdata <= rdData_nxt;
    end
end

endmodule
`default_nettype wire

// file: bench/gpcb_checker.sv
/*
 * Assertions on the bus slave and on the pin 0 to 7 drivers.
 * Assumes binding to gpcb_top and the map header on the include path.
 */
`timescale 1ns/10ps
`default_nettype none
`include "gpcb_map.vh"
module gpcb_checker (
    input wire logic clock,
    input wire logic resetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic [15:0] pinOut,
    input wire logic [15:0] pinOe
);
    logic wPend_r;
    logic lock_r;
    logic [11:0] wAddr_r;
    logic [31:0] cfgLo_r;
    logic taken;
    logic wLocked;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    assign taken = hsel && htrans[1] && hready;
    assign wLocked = wPend_r && hready && wAddr_r == `GPCB_OFS_CFG_LOW && !lock_r;
    // Shadow of the lock and of the low group, from bus traffic
    always @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            wPend_r <= 1'b0;
            lock_r <= 1'b0;
            wAddr_r <= 12'h000;
            cfgLo_r <= 32'h00000000;
        end
        else if (hready)
        begin
            wPend_r <= taken && hwrite;
            wAddr_r <= haddr[11:0];
            if (wPend_r && wAddr_r == `GPCB_OFS_LOCK_KEY)
                lock_r <= hwdata == `GPCB_KEY_OPEN;
            if (wPend_r && wAddr_r == `GPCB_OFS_CFG_LOW && lock_r)
                cfgLo_r <= hwdata;
        end
    end
    property p_okay;
        hresp == 1'b0;
    endproperty
    a_okay: assert property (p_okay) else $error("hresp not okay");
    property p_rdWait;
        taken && !hwrite |=> !hreadyout ##1 hreadyout;
    endproperty
    a_rdWait: assert property (p_rdWait) else $error("read wait wrong");
    property p_wrNoWait;
        taken && hwrite |=> hreadyout;
    endproperty
    a_wrNoWait: assert property (p_wrNoWait) else $error("write stalled");
    property p_dataHold;
        !$stable(hrdata) |-> $rose(hreadyout);
    endproperty
    a_dataHold: assert property (p_dataHold) else $error("hrdata moved");
    genvar k;
    for (k = 0; k < 8; k = k + 1)
    begin : pinChk
        logic [1:0] md;
        assign md = cfgLo_r[4*k+`GPCB_FLD_MODE_HI -: 2];
        property p_mode0;
            @(posedge clock) disable iff (!resetn)
            md == 2'h0 && $stable(cfgLo_r) |-> !pinOe[k] && !pinOut[k];
        endproperty
        a_mode0: assert property (p_mode0) else $error("disabled pin drives");
        property p_driven_both_ways;
            @(posedge clock) disable iff (!resetn)
            md == 2'h1 && $stable(cfgLo_r) |-> pinOe[k];
        endproperty
        a_driven_both_ways: assert property (p_driven_both_ways) else $error("push-pull off");
        property p_drain;
            @(posedge clock) disable iff (!resetn)
            md == 2'h2 && $stable(cfgLo_r) |-> !pinOut[k];
        endproperty
        a_drain: assert property (p_drain) else $error("open drain high");
    end
    property p_lockHold;
        wLocked |=> $stable(pinOe) [*2];
    endproperty
    a_lockHold: assert property (p_lockHold) else $error("locked write took");
    c_read: cover property (taken && !hwrite);
    c_locked: cover property (wLocked);
    c_drive: cover property (cfgLo_r[6:5] == 2'h1 && pinOe[1]);
    c_drain: cover property (cfgLo_r[10:9] == 2'h2 && !pinOut[2]);
endmodule
bind gpcb_top gpcb_checker i_chk (.clock, .resetn, .hsel, .haddr, .htrans, .hwrite,
    .hwdata, .hready, .hreadyout, .hresp, .hrdata, .pinOut, .pinOe);
`default_nettype wire

// file: bench/gpcb_pad_model.sv
/*
 * Pads: the bank's driver wins where enabled, else the outside level.
 * Assumes the outside level is always driven by the bench.
 */
`timescale 1ns/10ps
`default_nettype none
module gpcb_pad_model (
    input wire logic [15:0] pinOut,
    input wire logic [15:0] pinOe,
    input wire logic [15:0] extLevel,
    output logic [15:0] padLevel
);
    assign padLevel = (pinOe & pinOut) | (~pinOe & extLevel);
endmodule
`default_nettype wire

// file: bench/gpio_pin_config_bank_tb_top.sv
/*
 * Self-checking bench of the pin configuration bank.
 * Assumes gpcb_top, the pad model and the checker are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none
`include "gpcb_map.vh"
module gpio_pin_config_bank_tb_top;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [15:0] extLevel = 16'h0;
    wire hreadyout;
    wire hresp;
    wire irq;
    wire [31:0] hrdata;
    wire [15:0] pinOut;
    wire [15:0] pinOe;
    wire [15:0] padLevel;
    logic [31:0] expQ[$];
    logic rdOut = 1'b0;
    int error_cnt = 0;
    int n_compared = 0;
    logic [63:0] cfg;
    logic [31:0] r;
    logic [15:0] dOut, triEn, exOut, exOe;
    always #50 clock = ~clock;
    gpcb_top i_dut (.clock, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .pinIn(padLevel),
        .pinOut, .pinOe, .irq);
    gpcb_pad_model i_pad (.pinOut, .pinOe, .extLevel, .padLevel);
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task give_verdict;
        $display("errors %0d, compares %0d", error_cnt, n_compared);
        if (error_cnt == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task waitRdy;
        int n;
        n = 0;
        @(posedge clock);
        while (hreadyout !== 1'b1)
        begin
            n++;
            if (n > 20)
            begin
                error_cnt++;
                $display("CHECK FAILED at %0t: bus wait timed out", $time);
                give_verdict;
            end
            @(posedge clock);
        end
    endtask
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {20'h0, a};
        waitRdy;
        htrans <= 2'h0;
        hwdata <= d;
        waitRdy;
    endtask
    task rd(input logic [11:0] a, input logic [31:0] e);
        expQ.push_back(e);
        xfer(1'b0, a, 32'h0);
    endtask
    // Read data monitor
    always @(posedge clock)
    begin
        if (rdOut && hreadyout)
            chk(hrdata, expQ.pop_front());
        rdOut <= (hsel && htrans[1] && !hwrite && hreadyout) || (rdOut && !hreadyout);
    end
    initial
    begin
        void'($urandom(32'hd3af));
        repeat (8) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        rd(`GPCB_OFS_CFG_LOW, 32'h0);
        rd(12'h080, 32'h0);
        xfer(1'b1, `GPCB_OFS_CFG_LOW, $urandom);
        rd(`GPCB_OFS_CFG_LOW, 32'h0);
        xfer(1'b1, `GPCB_OFS_LOCK_KEY, `GPCB_KEY_OPEN);
        r = $urandom;
        xfer(1'b1, `GPCB_OFS_CFG_HIGH, r);
        xfer(1'b1, `GPCB_OFS_LOCK_KEY, 32'h0);
        xfer(1'b1, `GPCB_OFS_CFG_HIGH, ~r);
        rd(`GPCB_OFS_CFG_HIGH, r);
        xfer(1'b1, `GPCB_OFS_LOCK_KEY, `GPCB_KEY_OPEN);
        // Every mode, pin by pin across both groups
        for (int p = 0; p < 16; p++)
            cfg[p*4 +: 4] = {p[3], p[1:0], p[2]};
        dOut = $urandom;
        triEn = $urandom;
        extLevel <= $urandom;
        xfer(1'b1, `GPCB_OFS_CFG_LOW, cfg[31:0]);
        xfer(1'b1, `GPCB_OFS_CFG_HIGH, cfg[63:32]);
        xfer(1'b1, `GPCB_OFS_PIN_DATA_OUT, {16'h0, dOut});
        xfer(1'b1, `GPCB_OFS_TRI_ENABLE, {16'h0, triEn});
        rd(`GPCB_OFS_CFG_LOW, cfg[31:0]);
        for (int p = 0; p < 16; p++)
        begin
            exOe[p] = p % 4 == 1 || (p % 4 == 2 && !dOut[p]) || (p % 4 == 3 && triEn[p]);
            exOut[p] = (p % 4 == 1 || p % 4 == 3) && dOut[p];
        end
        repeat (8) @(posedge clock);
        chk({pinOe, pinOut}, {exOe, exOut});
        rd(`GPCB_OFS_PIN_DATA_IN, {16'h0, (padLevel & ~16'hf0f0)});
        // Edges: even pins rising, odd pins falling
        xfer(1'b1, `GPCB_OFS_CFG_LOW, 32'h80808080);
        xfer(1'b1, `GPCB_OFS_CFG_HIGH, 32'h80808080);
        extLevel <= 16'h0;
        xfer(1'b1, `GPCB_OFS_IRQ_ENABLE, 32'haaaa);
        repeat (8) @(posedge clock);
        xfer(1'b1, `GPCB_OFS_IRQ_CLEAR, 32'hffff);
        extLevel <= 16'hffff;
        repeat (8) @(posedge clock);
        rd(`GPCB_OFS_IRQ_STATUS, 32'h5555);
        chk(irq, 32'h0);
        extLevel <= 16'h0;
        repeat (8) @(posedge clock);
        rd(`GPCB_OFS_IRQ_STATUS, 32'hffff);
        chk(irq, 32'h1);
        xfer(1'b1, `GPCB_OFS_IRQ_CLEAR, 32'hffff);
        rd(`GPCB_OFS_IRQ_STATUS, 32'h0);
        repeat (3) @(posedge clock);
        chk(irq, 32'h0);
        give_verdict;
    end
endmodule
`default_nettype wire
